//--- rtl/adcr_cfg_if.sv
// Purpose: Link between serial port and register bank
// Assumes: One clock domain, write strobe is a one-cycle pulse
// Notes: Address is valid for reads once the address byte is in
`timescale 1ns/1ps
interface adcr_cfg_if;
    logic wr_stb;
    logic [6:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    modport port (output wr_stb, output addr, output wdata, input rdata);
    modport bank (input wr_stb, input addr, input wdata, output rdata);
endinterface

//--- rtl/adcr_output_config.sv
// Purpose: Output clock, driver and format configuration of a dual ADC
// Assumes: Samples arrive on clk with a valid strobe; serial pins synced inside the serial port
// Notes: Analog settings leave as register-driven control levels
`timescale 1ns/1ps
// Function
// (RULE1) Timing bit 3 inverts the output clock polarity.
// (RULE2) Timing bits 2-1 pick output clock delay: none, 1/8, 1/4, 3/8.
// (RULE3) Host enables the duty cycle stabilizer whenever phase delay is used.
// (RULE4) Timing bit 0 switches the duty cycle stabilizer on or off.
// (RULE5) Timing bits 7-4 are ignored.
// (RULE6) Driver bits 6-4 select LVDS current; code 011 unused.
// (RULE7) Driver bit 3 enables internal termination and doubles drive current.
// (RULE8) Driver bit 2 high disables outputs to high impedance.
// (RULE9) Host should nap or sleep both channels when outputs are disabled.
// (RULE10) Driver bits 1-0 pick full-rate, DDR LVDS or DDR single-ended.
// (RULE11) Format bits 5-3 pick off, zeros, ones, checkerboard or alternating.
// (RULE12) Alternating toggles all bits; checkerboard swaps two complements.
// (RULE13) Format bit 2 sets alternate bit polarity and forces offset binary.
// (RULE14) Format bit 1 enables the output randomizer.
// (RULE15) Format bit 0 selects two's complement, else offset binary.
// (RULE16) Registers decode at addresses 02h, 03h and 04h, eight bits each.
// (RULE17) A transfer is read/write bit, seven address bits, eight data bits.
// (RULE18) First sixteen rising serial clocks latch data; chip select ends it.
// (RULE19) Reads return register data, change nothing and ignore input data.
// (RULE20) Software reset clears all mode registers to 00h.
// (RULE21) New values reach the outputs only after a complete write.
module adcr_output_config
    import adcr_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Serial configuration pins
    input wire logic cs_n,
    input wire logic sck,
    input wire logic sdi,
    output logic sdo_o,
    output logic sdo_oe_n,
    // Converter samples
    input wire logic sample_valid,
    input wire logic [15:0] sample_data,
    input wire logic sample_overflow,
    // Formatted output data
    output logic out_valid,
    output logic [15:0] out_data,
    output logic overflow_flag,
    output logic out_oe_n,
    output logic sample_clock_out,
    // Clock, driver and power-down controls
    output logic output_clock_invert,
    output logic [1:0] output_clock_phase_delay,
    output logic duty_cycle_stabilizer_en,
    output logic [2:0] lvds_drive_current,
    output logic lvds_internal_term_en,
    output logic lvds_current_double,
    output logic output_disable,
    output logic [1:0] output_format_select,
    output logic [1:0] power_down_mode
);
    adcr_cfg_if cfg_bus ();

    logic [7:0] pwr_reg, next_pwr_reg;
    logic [7:0] output_clock_timing, next_output_clock_timing;
    logic [7:0] output_driver_config, next_output_driver_config;
    logic [7:0] sample_format_config, next_sample_format_config;
    logic [2:0] test_pattern_select;
    logic alternate_bit_polarity_en;
    logic output_scrambler_en;
    logic twos_complement_en;
    logic pat_phase, next_pat_phase;
    logic [15:0] next_out_data;
    logic next_overflow;
    logic next_out_valid;
    logic clk_toggle, next_clk_toggle;
    logic [15:0] coded;

    // Serial front end
    adcr_serial_port adcr_serial_port_i (
        .clk(clk),
        .srst(srst),
        .cs_n(cs_n),
        .sck(sck),
        .sdi(sdi),
        .sdo_o(sdo_o),
        .sdo_oe_n(sdo_oe_n),
        .cfg(cfg_bus.port)
    );

    // Register writes land only on the end-of-word strobe
    always_comb
    begin
        next_pwr_reg = pwr_reg;
        next_output_clock_timing = output_clock_timing;
        next_output_driver_config = output_driver_config;
        next_sample_format_config = sample_format_config;
        if (cfg_bus.wr_stb)
        begin
            unique case (cfg_bus.addr)
                ADDR_SOFT_RESET:
                begin
                    if (cfg_bus.wdata[SOFT_RESET_POS])
                    begin
                        // Self-clearing: nothing of it is stored
                        next_pwr_reg = REG_RESET_VAL; // (RULE20)
                        next_output_clock_timing = REG_RESET_VAL;
                        next_output_driver_config = REG_RESET_VAL;
                        next_sample_format_config = REG_RESET_VAL;
                    end
                end
                ADDR_POWER_DOWN:
                    next_pwr_reg = cfg_bus.wdata & MASK_POWER_DOWN;
                ADDR_CLOCK_TIMING:
                    next_output_clock_timing =
                        cfg_bus.wdata & MASK_CLOCK_TIMING; // (RULE5) (RULE16)
                ADDR_DRIVER_CONFIG:
                    next_output_driver_config =
                        cfg_bus.wdata & MASK_DRIVER_CONFIG; // (RULE16)
                ADDR_FORMAT_CONFIG:
                    next_sample_format_config =
                        cfg_bus.wdata & MASK_FORMAT_CONFIG; // (RULE16)
                default:
                    next_pwr_reg = pwr_reg;
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            pwr_reg <= REG_RESET_VAL;
            output_clock_timing <= REG_RESET_VAL;
            output_driver_config <= REG_RESET_VAL;
            sample_format_config <= REG_RESET_VAL;
        end
        else
        begin
            pwr_reg <= next_pwr_reg;
            output_clock_timing <= next_output_clock_timing;
            output_driver_config <= next_output_driver_config;
            sample_format_config <= next_sample_format_config;
        end
    end

    // Read mux; unmapped and write-only addresses read as zero
    always_comb
    begin
        unique case (cfg_bus.addr)
            ADDR_POWER_DOWN: cfg_bus.rdata = pwr_reg;
            ADDR_CLOCK_TIMING: cfg_bus.rdata = output_clock_timing;
            ADDR_DRIVER_CONFIG: cfg_bus.rdata = output_driver_config;
            ADDR_FORMAT_CONFIG: cfg_bus.rdata = sample_format_config;
            default: cfg_bus.rdata = 8'h00;
        endcase
    end

    // Control fields straight from the registers
    assign output_clock_invert =
        output_clock_timing[CLK_INVERT_POS]; // (RULE1)
    assign output_clock_phase_delay =
        output_clock_timing[CLK_PHASE_LSB +: 2]; // (RULE2)
    assign duty_cycle_stabilizer_en =
        output_clock_timing[STABILIZER_POS]; // (RULE4)
    assign lvds_drive_current =
        output_driver_config[LVDS_CUR_LSB +: 3]; // (RULE6)
    assign lvds_internal_term_en = output_driver_config[TERM_POS]; // (RULE7)
    assign lvds_current_double = output_driver_config[TERM_POS]; // (RULE7)
    assign output_disable = output_driver_config[OUT_DISABLE_POS]; // (RULE8)
    assign out_oe_n = output_driver_config[OUT_DISABLE_POS]; // (RULE8)
    assign output_format_select =
        output_driver_config[OUT_FMT_LSB +: 2]; // (RULE10)
    assign power_down_mode = pwr_reg[1:0];
    assign test_pattern_select =
        sample_format_config[TEST_PAT_LSB +: 3]; // (RULE11)
    assign alternate_bit_polarity_en = sample_format_config[POLARITY_POS];
    assign output_scrambler_en = sample_format_config[SCRAMBLE_POS];
    assign twos_complement_en = sample_format_config[TWOS_POS];

    // Coding chain: format, then randomizer, then bit polarity
    always_comb
    begin
        coded = sample_data;
        // Polarity mode overrides two's complement
        if (twos_complement_en && !alternate_bit_polarity_en)
            coded[15] = ~coded[15]; // (RULE13) (RULE15)
        // Randomizer folds the LSB into every upper bit
        if (output_scrambler_en)
            coded[15:1] = coded[15:1] ^ {15{coded[0]}}; // (RULE14)
        if (alternate_bit_polarity_en)
            coded = coded ^ ODD_BITS; // (RULE13)
    end

    // Output stage, advanced once per sample
    always_comb
    begin
        next_out_valid = sample_valid;
        next_out_data = out_data;
        next_overflow = overflow_flag;
        next_pat_phase = pat_phase;
        next_clk_toggle = clk_toggle;
        if (sample_valid)
        begin
            next_clk_toggle = ~clk_toggle;
            next_pat_phase = ~pat_phase;
            unique case (test_pattern_select) // (RULE11)
                PAT_ZEROS:
                begin
                    next_out_data = 16'h0000;
                    next_overflow = 1'b0;
                end
                PAT_ONES:
                begin
                    next_out_data = 16'hffff;
                    next_overflow = 1'b1;
                end
                PAT_CHECKER:
                begin
                    // Two complementary interleaved words
                    next_out_data = pat_phase ? ~CHECKER_WORD
                        : CHECKER_WORD; // (RULE12)
                    next_overflow = ~pat_phase;
                end
                PAT_ALTERNATE:
                begin
                    next_out_data = {16{pat_phase}}; // (RULE12)
                    next_overflow = pat_phase;
                end
                default:
                begin
                    // Unused codes behave as patterns off
                    next_out_data = coded;
                    next_overflow = sample_overflow;
                end
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            out_valid <= 1'b0;
            out_data <= 16'h0000;
            overflow_flag <= 1'b0;
            pat_phase <= 1'b0;
            clk_toggle <= 1'b0;
        end
        else
        begin
            out_valid <= next_out_valid;
            out_data <= next_out_data;
            overflow_flag <= next_overflow;
            pat_phase <= next_pat_phase;
            clk_toggle <= next_clk_toggle;
        end
    end

    // Sample clock image; real phase delay is applied by the analog driver
    assign sample_clock_out = clk_toggle ^ output_clock_invert; // (RULE1)
endmodule

//--- rtl/adcr_pkg.sv
// Purpose: Shared constants for the converter output configuration block
// Assumes: 8-bit registers reached over a 16-bit serial word
// Notes: Don't-care bits are stored as zero and read back as zero
package adcr_pkg;
    // Serial word layout
    localparam int WORD_BITS = 16;
    localparam logic [4:0] CNT_ADDR_DONE = 5'h08;
    localparam logic [4:0] CNT_WORD_DONE = 5'h10;
    localparam int RW_POS = 15;
    // Register addresses
    localparam logic [6:0] ADDR_SOFT_RESET = 7'h00;
    localparam logic [6:0] ADDR_POWER_DOWN = 7'h01;
    localparam logic [6:0] ADDR_CLOCK_TIMING = 7'h02;
    localparam logic [6:0] ADDR_DRIVER_CONFIG = 7'h03;
    localparam logic [6:0] ADDR_FORMAT_CONFIG = 7'h04;
    // Reset values and writable bit masks
    localparam logic [7:0] REG_RESET_VAL = 8'h00;
    localparam logic [7:0] MASK_POWER_DOWN = 8'h03;
    localparam logic [7:0] MASK_CLOCK_TIMING = 8'h0f;
    localparam logic [7:0] MASK_DRIVER_CONFIG = 8'h7f;
    localparam logic [7:0] MASK_FORMAT_CONFIG = 8'h3f;
    // Field positions
    localparam int SOFT_RESET_POS = 7;
    localparam int CLK_INVERT_POS = 3;
    localparam int CLK_PHASE_LSB = 1;
    localparam int STABILIZER_POS = 0;
    localparam int LVDS_CUR_LSB = 4;
    localparam int TERM_POS = 3;
    localparam int OUT_DISABLE_POS = 2;
    localparam int OUT_FMT_LSB = 0;
    localparam int TEST_PAT_LSB = 3;
    localparam int POLARITY_POS = 2;
    localparam int SCRAMBLE_POS = 1;
    localparam int TWOS_POS = 0;
    // Test pattern codes
    localparam logic [2:0] PAT_OFF = 3'h0;
    localparam logic [2:0] PAT_ZEROS = 3'h1;
    localparam logic [2:0] PAT_ONES = 3'h3;
    localparam logic [2:0] PAT_CHECKER = 3'h5;
    localparam logic [2:0] PAT_ALTERNATE = 3'h7;
    // Checkerboard and alternate bit masks
    localparam logic [15:0] CHECKER_WORD = 16'h5555;
    localparam logic [15:0] ODD_BITS = 16'haaaa;
endpackage

//--- rtl/adcr_serial_port.sv
// Purpose: Serial slave that decodes 16-bit read/write words
// Assumes: Serial pins are asynchronous and slow against clk
// Notes: Read data leaves on falling serial clock edges, MSB first
`timescale 1ns/1ps
module adcr_serial_port
    import adcr_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Serial pins
    input wire logic cs_n,
    input wire logic sck,
    input wire logic sdi,
    output logic sdo_o,
    output logic sdo_oe_n,
    // Register bank side
    adcr_cfg_if.port cfg
);
    typedef enum logic {ADCR_IDLE, ADCR_XFER} adcr_state_e;

    logic [2:0] meta;
    logic [2:0] sync;
    logic sck_d;
    adcr_state_e state, next_state;
    logic [4:0] bit_cnt, next_bit_cnt;
    logic [15:0] shreg, next_shreg;
    logic [7:0] rd_shift, next_rd_shift;
    logic rd_active, next_rd_active;
    logic wr_stb, next_wr_stb;
    logic sck_rise;
    logic sck_fall;

    // Two-stage synchronisers; only the second stage is read
    always_ff @(posedge clk)
    begin
        meta <= {cs_n, sck, sdi};
        sync <= meta;
        sck_d <= sync[1];
    end

    assign sck_rise = sync[1] & ~sck_d;
    assign sck_fall = ~sync[1] & sck_d;

    // Transfer sequencing
    always_comb
    begin
        next_state = state;
        next_bit_cnt = bit_cnt;
        next_shreg = shreg;
        next_rd_shift = rd_shift;
        next_rd_active = rd_active;
        next_wr_stb = 1'b0;
        unique case (state)
            ADCR_IDLE:
            begin
                next_rd_active = 1'b0;
                if (!sync[2])
                begin
                    next_state = ADCR_XFER;
                    next_bit_cnt = 5'h00;
                end
            end
            ADCR_XFER:
            begin
                if (sync[2])
                begin
                    // Write only on a complete word; reads change nothing
                    next_state = ADCR_IDLE; // (RULE18)
                    next_rd_active = 1'b0;
                    next_wr_stb = (bit_cnt == CNT_WORD_DONE)
                        & ~shreg[RW_POS]; // (RULE17) (RULE19) (RULE21)
                end
                else if (sck_rise && bit_cnt != CNT_WORD_DONE)
                begin
                    // Edges past the sixteenth are dropped
                    next_shreg = {shreg[14:0], sync[0]}; // (RULE18)
                    next_bit_cnt = bit_cnt + 5'h01;
                end
                else if (sck_fall && bit_cnt == CNT_ADDR_DONE
                    && shreg[7] && !rd_active)
                begin
                    // Read word: load register after the address byte
                    next_rd_active = 1'b1; // (RULE19)
                    next_rd_shift = cfg.rdata;
                end
                else if (sck_fall && rd_active && bit_cnt > CNT_ADDR_DONE)
                begin
                    next_rd_shift = {rd_shift[6:0], 1'b0};
                end
            end
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            state <= ADCR_IDLE;
            bit_cnt <= 5'h00;
            shreg <= 16'h0000;
            rd_shift <= 8'h00;
            rd_active <= 1'b0;
            wr_stb <= 1'b0;
        end
        else
        begin
            state <= next_state;
            bit_cnt <= next_bit_cnt;
            shreg <= next_shreg;
            rd_shift <= next_rd_shift;
            rd_active <= next_rd_active;
            wr_stb <= next_wr_stb;
        end
    end

    // Address comes from the low byte while reading, high byte at the end
    assign cfg.addr = (bit_cnt == CNT_WORD_DONE) ? shreg[14:8] : shreg[6:0];
    assign cfg.wdata = shreg[7:0];
    assign cfg.wr_stb = wr_stb;

    // Open drain: pull low only for a zero read bit
    assign sdo_o = 1'b0;
    assign sdo_oe_n = ~(rd_active & ~rd_shift[7]); // (RULE19)
endmodule

//--- tb/adcr_host_model.sv
// Purpose: Host side of the serial configuration port
// Assumes: Serial clock high level lasts five clk cycles, low level ten
// Notes: SDO has a pull-up; released SDI shows the inverse level
`timescale 1ns/1ps
module adcr_host_model (
    // Clock
    input wire logic clk,
    // Serial pins
    output logic cs_n,
    output logic sck,
    output logic sdi,
    input wire logic sdo_o,
    input wire logic sdo_oe_n
);
    logic sdo_line;
    // Open-drain wire with external pull-up
    assign sdo_line = sdo_oe_n ? 1'b1 : sdo_o;
    // Idle pins at time zero
    initial
    begin
        cs_n = 1'b1;
        sck = 1'b0;
        sdi = 1'b0;
    end
    // One frame of nb rising edges; bits past 16 come from junk
    task automatic xfer(input logic [15:0] w, input int nb,
        input logic [31:0] junk, output logic [7:0] rd);
        rd = 8'h00;
        @(posedge clk);
        cs_n <= 1'b0;
        for (int i = 0; i < nb; i++)
        begin
            sdi <= (i < 16) ? w[15 - i] : junk[i];
            repeat (5) @(posedge clk);
            sck <= 1'b1;
            repeat (5) @(posedge clk);
            sck <= 1'b0;
            repeat (5) @(posedge clk);
            if (i >= 7 && i <= 14)
                rd[14 - i] = sdo_line;
        end
        cs_n <= 1'b1;
        sdi <= ~sdi;
        repeat (8) @(posedge clk);
    endtask
endmodule

//--- tb/adcr_output_config_assertions.sv
// Purpose: Port-level checks of the output configuration block
// Assumes: One clock, srst disables every check
// Notes: Bound to the top module from the bench top file
`timescale 1ns/1ps
module adcr_output_config_assertions (
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Serial pins
    input wire logic cs_n,
    input wire logic sdo_o,
    input wire logic sdo_oe_n,
    // Sample path
    input wire logic sample_valid,
    input wire logic out_valid,
    input wire logic out_oe_n,
    input wire logic sample_clock_out,
    // Controls
    input wire logic output_clock_invert,
    input wire logic [1:0] output_clock_phase_delay,
    input wire logic duty_cycle_stabilizer_en,
    input wire logic [2:0] lvds_drive_current,
    input wire logic lvds_internal_term_en,
    input wire logic lvds_current_double,
    input wire logic output_disable,
    input wire logic [1:0] output_format_select
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);
    // Control levels except lvds_current_double as one word
    wire logic [10:0] cfg = {output_clock_invert, output_clock_phase_delay,
        duty_cycle_stabilizer_en, lvds_drive_current, lvds_internal_term_en,
        output_disable, output_format_select};
    valid_follow_a:
        assert property (out_valid == $past(sample_valid))
        else $error("out_valid does not follow sample_valid");
    oe_mirror_a:
        assert property (out_oe_n == output_disable)
        else $error("out_oe_n differs from output_disable");
    term_double_a:
        assert property (lvds_current_double == lvds_internal_term_en)
        else $error("current doubling differs from termination");
    cfg_whole_word_a:
        assert property ($changed(cfg) |-> $past(cs_n, 1) && $past(cs_n, 2))
        else $error("control changed inside a serial frame");
    sdo_idle_a:
        assert property (cs_n [*4] |-> sdo_oe_n)
        else $error("sdo driven outside a frame");
    sdo_drain_a:
        assert property (sdo_o == 1'b0)
        else $error("sdo_o is not the open-drain low level");
    sdo_frame_a:
        assert property ($fell(sdo_oe_n) |-> !$past(cs_n, 2))
        else $error("sdo pulled low without chip select");
    ckout_toggle_a:
        assert property ($changed(sample_clock_out) ==
            (out_valid ^ $changed(output_clock_invert)))
        else $error("sample_clock_out toggle mismatch");
endmodule

//--- tb/adcr_output_config_tb.sv
// Purpose: Self-checking bench of the output configuration block
// Assumes: Host model drives the serial pins, bench drives samples
// Notes: Expected samples queue up and are popped as out_valid shows
`timescale 1ns/1ps
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin \
error_cnt++; $display("BAD %s exp %h got %h", nm, e, g); end end
module adcr_output_config_tb;
    import adcr_pkg::*;
    logic clk, srst, cs_n, sck, sdi, sdo_o, sdo_oe_n, sample_valid;
    logic sample_overflow, out_valid, overflow_flag, out_oe_n;
    logic sample_clock_out, output_clock_invert, duty_cycle_stabilizer_en;
    logic lvds_internal_term_en, lvds_current_double, output_disable;
    logic [15:0] sample_data, out_data;
    logic [1:0] output_clock_phase_delay, output_format_select;
    logic [1:0] power_down_mode;
    logic [2:0] lvds_drive_current;
    logic [31:0] lfsr = 32'h298e;
    logic [16:0] expq[$];
    logic [7:0] fmts[10] = '{8'h00, 8'h01, 8'h02, 8'h04, 8'h05,
        8'h08, 8'h18, 8'h28, 8'h38, 8'h10};
    int error_cnt = 0;
    int comparisons = 0;
    wire logic [10:0] cfg = {output_clock_invert, output_clock_phase_delay,
        duty_cycle_stabilizer_en, lvds_drive_current, lvds_internal_term_en,
        output_disable, output_format_select};
    adcr_output_config adcr_output_config_i (.clk(clk), .srst(srst),
        .cs_n(cs_n), .sck(sck), .sdi(sdi), .sdo_o(sdo_o),
        .sdo_oe_n(sdo_oe_n), .sample_valid(sample_valid),
        .sample_data(sample_data), .sample_overflow(sample_overflow),
        .out_valid(out_valid), .out_data(out_data),
        .overflow_flag(overflow_flag), .out_oe_n(out_oe_n),
        .sample_clock_out(sample_clock_out),
        .output_clock_invert(output_clock_invert),
        .output_clock_phase_delay(output_clock_phase_delay),
        .duty_cycle_stabilizer_en(duty_cycle_stabilizer_en),
        .lvds_drive_current(lvds_drive_current),
        .lvds_internal_term_en(lvds_internal_term_en),
        .lvds_current_double(lvds_current_double),
        .output_disable(output_disable),
        .output_format_select(output_format_select),
        .power_down_mode(power_down_mode));
    adcr_host_model adcr_host_model_i (.clk(clk), .cs_n(cs_n), .sck(sck),
        .sdi(sdi), .sdo_o(sdo_o), .sdo_oe_n(sdo_oe_n));
    // Free-running 100 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    function automatic logic [31:0] lfsr_next(logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    // Reference coding; unused pattern codes fall through to data
    function automatic logic [16:0] fmt_exp(logic [7:0] f,
        logic [15:0] d, logic ov, logic ph);
        logic [15:0] x;
        x = d;
        case (f[5:3])
            3'h1: return 17'h00000;
            3'h3: return 17'h1ffff;
            3'h5: return ph ? {1'b0, 16'haaaa} : {1'b1, 16'h5555};
            3'h7: return {17{ph}};
            default: ;
        endcase
        if (f[0] && !f[2])
            x[15] = ~x[15];
        if (f[1])
            x[15:1] = x[15:1] ^ {15{x[0]}};
        if (f[2])
            x = x ^ 16'haaaa;
        return {ov, x};
    endfunction
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        logic [7:0] rd;
        lfsr = lfsr_next(lfsr);
        adcr_host_model_i.xfer({1'b0, a, d}, 16, lfsr, rd);
    endtask
    // Read with junk in the data bits
    task automatic rdchk(input logic [6:0] a, input logic [7:0] e);
        logic [7:0] rd;
        lfsr = lfsr_next(lfsr);
        adcr_host_model_i.xfer({1'b1, a, lfsr[7:0]}, 16, lfsr, rd);
        `CHK("readback", e, rd)
    endtask
    task automatic summarize();
        $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // Scoreboard: pop the oldest expectation per output sample
    initial
    begin
        logic [16:0] e;
        forever
        begin
            @(negedge clk);
            if (out_valid === 1'b1)
            begin
                e = (expq.size() > 0) ? expq.pop_front() : 17'hxxxxx;
                `CHK("sample", e, {overflow_flag, out_data})
            end
        end
    end
    // Watchdog against a hung run
    initial
    begin
        repeat (60000) @(posedge clk);
        error_cnt++;
        summarize();
    end
    // Main sequence
    initial
    begin
        logic [7:0] d;
        logic [7:0] rd;
        logic ph;
        ph = 1'b0;
        srst = 1'b1;
        sample_valid = 1'b0;
        sample_data = 16'h0000;
        sample_overflow = 1'b0;
        repeat (16) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        `CHK("reset cfg", 11'h000, cfg)
        `CHK("reset oe", 2'b10, {sdo_oe_n, out_oe_n})
        $display("test reset done");
        for (int p = 0; p < 4; p++)
        begin
            d = {4'ha, p[0], p[1:0], 1'b1};
            wr(ADDR_CLOCK_TIMING, d);
            `CHK("timing", d[3:0], cfg[10:7])
        end
        rdchk(ADDR_CLOCK_TIMING, 8'h0f);
        $display("test timing done");
        wr(ADDR_POWER_DOWN, 8'h03);
        `CHK("power down", 2'h3, power_down_mode)
        for (int c = 0; c < 8; c++)
        begin
            if (c == 3)
                continue;
            d = {1'b1, c[2:0], c[0], c[1], 2'(c % 3)};
            wr(ADDR_DRIVER_CONFIG, d);
            `CHK("driver", d[6:0], cfg[6:0])
            `CHK("double", d[3], lvds_current_double)
            `CHK("oe pin", d[2], out_oe_n)
            rdchk(ADDR_DRIVER_CONFIG, {1'b0, d[6:0]});
        end
        wr(ADDR_DRIVER_CONFIG, 8'h00);
        wr(ADDR_POWER_DOWN, 8'h00);
        $display("test driver done");
        foreach (fmts[k])
        begin
            wr(ADDR_FORMAT_CONFIG, fmts[k]);
            repeat (30)
            begin
                @(posedge clk);
                lfsr = lfsr_next(lfsr);
                sample_valid <= lfsr[0];
                sample_data <= lfsr[16:1];
                sample_overflow <= lfsr[17];
                if (lfsr[0])
                    expq.push_back(fmt_exp(fmts[k], lfsr[16:1], lfsr[17], ph));
                ph ^= lfsr[0];
            end
            @(posedge clk);
            sample_valid <= 1'b0;
            repeat (3) @(posedge clk);
        end
        $display("test format done");
        adcr_host_model_i.xfer({1'b0, ADDR_DRIVER_CONFIG, 8'h55}, 8, lfsr, rd);
        `CHK("short word", 7'h00, cfg[6:0])
        adcr_host_model_i.xfer({1'b0, ADDR_DRIVER_CONFIG, 8'h21}, 20,
            32'hffffffff, rd);
        `CHK("long word", 7'h21, cfg[6:0])
        rdchk(ADDR_DRIVER_CONFIG, 8'h21);
        `CHK("read keeps", 7'h21, cfg[6:0])
        wr(7'h05, 8'hff);
        rdchk(7'h05, 8'h00);
        $display("test serial done");
        wr(ADDR_POWER_DOWN, 8'h02);
        wr(ADDR_SOFT_RESET, 8'h80);
        `CHK("soft reset", 11'h000, cfg)
        `CHK("soft pd", 2'h0, power_down_mode)
        rdchk(ADDR_FORMAT_CONFIG, 8'h00);
        `CHK("queue empty", 32'd0, expq.size())
        $display("test soft reset done");
        summarize();
    end
endmodule
bind adcr_output_config adcr_output_config_assertions assertions_i (
    .clk(clk), .srst(srst), .cs_n(cs_n), .sdo_o(sdo_o),
    .sdo_oe_n(sdo_oe_n), .sample_valid(sample_valid),
    .out_valid(out_valid), .out_oe_n(out_oe_n),
    .sample_clock_out(sample_clock_out),
    .output_clock_invert(output_clock_invert),
    .output_clock_phase_delay(output_clock_phase_delay),
    .duty_cycle_stabilizer_en(duty_cycle_stabilizer_en),
    .lvds_drive_current(lvds_drive_current),
    .lvds_internal_term_en(lvds_internal_term_en),
    .lvds_current_double(lvds_current_double),
    .output_disable(output_disable),
    .output_format_select(output_format_select));
